// ---- hdl/rf_tag_command_decoder.sv ----
// Contactless tag command decoder, responder and read engine.
//
// How it works
// - Bytes travel low bit first both ways.
// - Wake-up short frames get ATQA; request short frames do too unless the tag is halted.
// - Cascade prefixes decode anticollision and select.
// - Sequence 50h 00h halts the tag.
// - Tag memory command codes are accepted.
// - Data memory command codes are accepted.
// - Lock command codes are accepted.
// - Selected tag takes halt or memory commands.
// - Frames framed by start bit and idle.
// - Reply not before n=9, within 5 ms.
// - Four-bit acknowledge and error codes.
// - ATQA 0044h, low byte first.
// - SAK 04h level one, 00h level two.
// - READ returns four blocks, sixteen bytes.
// - Start block beyond memory gets NAK.
// - READ wraps to block zero at end.
// - Protected unauthenticated READ start gets NAK.
// - Unprotected start wraps before protected block.
// - Authenticated tag ignores access protection.
// - Password and acknowledge bytes read as zero.
// - FAST_READ returns blocks start to end.
// - FAST_READ NAKs outside or protected blocks.
// - First protected block FFh disables protection.
// - Protection bit selects read protection.
`timescale 1ns/1ps
module rf_tag_command_decoder
  import rf_tag_pkg::*;
#(
  parameter int unsigned FDT_CYCLES = FDT_MIN_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_eof,
  input wire logic rx_parity_err,
  input wire tag_cfg_t cfg,
  input wire logic [39:0] uid_cl1,
  input wire logic [39:0] uid_cl2,
  input wire logic password_check_ok,
  output logic mem_rd_req,
  output logic [7:0] mem_addr,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rdata,
  output ext_cmd_t ext_cmd,
  output logic tx_bit_valid,
  output logic tx_bit,
  output logic tx_eof,
  input wire logic tx_bit_ready,
  output logic selected,
  output logic authenticated
);

  typedef enum logic [3:0] {
    TS_IDLE = 4'b0001,
    TS_READY = 4'b0010,
    TS_ACTIVE = 4'b0100,
    TS_HALT = 4'b1000
  } tag_state_t;

  typedef enum logic [5:0] {
    RS_IDLE = 6'b000001,
    RS_WAIT = 6'b000010,
    RS_FIXED = 6'b000100,
    RS_FETCH = 6'b001000,
    RS_WORD = 6'b010000,
    RS_CRC = 6'b100000
  } resp_state_t;

  // Receive side.
  logic [7:0] rx_shift_r;
  logic [2:0] rx_bitcnt_r;
  logic [3:0] rx_nbytes_r;
  logic [7:0] rx_buf_r [RX_MAX_BYTES];
  logic [15:0] rx_crc_r;
  logic [7:0] rx_byte;

  // Protocol and responder state.
  tag_state_t tag_state_r;
  tag_state_t tag_state_nxt;
  resp_state_t rs_r;
  logic auth_r;
  logic [39:0] fixed_r;
  logic [2:0] fixed_len_r;
  logic [3:0] fixed_bits_r;
  logic add_crc_r;
  logic [2:0] idx_r;
  logic [7:0] blk_r;
  logic [7:0] wrap_r;
  logic [8:0] blocks_left_r;
  logic [31:0] word_r;
  logic [15:0] tx_crc_r;
  logic [TIMER_W-1:0] timer_r;
  logic started_r;

  // Decode results.
  logic dec_go;
  logic dec_fixed;
  logic dec_read;
  logic dec_crc;
  logic [39:0] dec_bytes;
  logic [2:0] dec_len;
  logic [3:0] dec_bits;
  logic [7:0] dec_blk;
  logic [7:0] dec_wrap;
  logic [8:0] dec_count;
  logic dec_halt;
  logic dec_ext;

  // Buffer and serializer.
  tx_entry_t buf_r [BUF_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] buf_cnt_r;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic push;
  tx_entry_t push_entry;
  logic [7:0] ser_shift_r;
  logic [3:0] ser_left_r;
  logic ser_last_r;
  logic ser_busy_r;

  // Compares five received bytes with a cascade level's identifier, byte 0 in the low bits.
  function automatic logic uid_match(input logic [39:0] uid, input logic [39:0] got);
    return uid == got;
  endfunction : uid_match

  assign rx_byte = {rx_bit, rx_shift_r[7:1]};

  // Collects the frame; the running check sequence ends at zero when the trailer is right.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_r <= 8'h00;
      rx_bitcnt_r <= 3'h0;
      rx_nbytes_r <= 4'h0;
      rx_crc_r <= CRC_PRESET;
    end else if (rx_eof) begin
      rx_bitcnt_r <= 3'h0;
      rx_nbytes_r <= 4'h0;
      rx_crc_r <= CRC_PRESET;
    end else if (rx_bit_valid) begin
      rx_shift_r <= rx_byte;
      rx_bitcnt_r <= rx_bitcnt_r + 3'h1;
      if (rx_bitcnt_r == 3'h7) begin
        rx_crc_r <= crc_a_byte(rx_crc_r, rx_byte);
        if (rx_nbytes_r != RX_COUNT_MAX) begin
          rx_nbytes_r <= rx_nbytes_r + 4'h1;
        end
      end
    end
  end

  // Byte store; frames longer than the store keep only their head.
  generate
    for (genvar g = 0; g < RX_MAX_BYTES; g++) begin : g_rxbuf
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_buf_r[g] <= 8'h00;
        end else if (rx_bit_valid && !rx_eof && rx_bitcnt_r == 3'h7 && rx_nbytes_r == 4'(g)) begin
          rx_buf_r[g] <= rx_byte;
        end
      end
    end
  endgenerate

  // Frame decoder: picks the next tag state and the reply that follows.
  always_comb begin
    logic short_frame;
    logic crc_ok;
    logic protection_level_bit_on;
    logic [7:0] s;
    logic [7:0] e;
    logic [39:0] sel_uid;
    short_frame = rx_nbytes_r == 4'h0 && rx_bitcnt_r == 3'(SHORT_FRAME_BITS);
    crc_ok = rx_crc_r == 16'h0000 && !rx_parity_err && rx_bitcnt_r == 3'h0;
    protection_level_bit_on = cfg.protection_level_bit && cfg.first_protected_block != FIRST_PROTECTED_BLOCK_DISABLED && !auth_r;
    s = rx_buf_r[1];
    e = rx_buf_r[2];
    sel_uid = {rx_buf_r[6], rx_buf_r[5], rx_buf_r[4], rx_buf_r[3], rx_buf_r[2]};
    tag_state_nxt = tag_state_r;
    dec_fixed = 1'b0;
    dec_read = 1'b0;
    dec_crc = 1'b0;
    dec_bytes = 40'h0;
    dec_len = LEN_ONE;
    dec_bits = BITS_BYTE;
    dec_blk = s;
    dec_wrap = cfg.last_block;
    dec_count = BLOCKS_PER_READ;
    dec_halt = 1'b0;
    dec_ext = 1'b0;
    // wrap just before the protected block
    if (protection_level_bit_on && cfg.first_protected_block <= cfg.last_block) begin
      dec_wrap = cfg.first_protected_block - 8'h01;
    end
    if (short_frame && (rx_shift_r[7:1] == CMD_WAKEUP ||
        (rx_shift_r[7:1] == CMD_REQUEST && tag_state_r != TS_HALT))) begin
      tag_state_nxt = TS_READY;
      dec_fixed = 1'b1;
      dec_bytes = {24'h0, ATQA_VALUE};
      dec_len = LEN_ATQA;
    end else if (tag_state_r == TS_HALT || tag_state_r == TS_IDLE) begin
      tag_state_nxt = tag_state_r;
    end else if (tag_state_r == TS_READY) begin
      tag_state_nxt = TS_IDLE;
      if (rx_nbytes_r == LEN_ANTICOLL && rx_bitcnt_r == 3'h0 && rx_buf_r[1] == NVB_ANTICOLL &&
          (rx_buf_r[0] == SEL_CL1 || rx_buf_r[0] == SEL_CL2)) begin
        tag_state_nxt = TS_READY;
        dec_fixed = 1'b1;
        dec_bytes = (rx_buf_r[0] == SEL_CL1) ? uid_cl1 : uid_cl2;
        dec_len = LEN_UID;
      end else if (rx_nbytes_r == LEN_SELECT && crc_ok && rx_buf_r[1] == NVB_SELECT) begin
        if (rx_buf_r[0] == SEL_CL1 && uid_match(uid_cl1, sel_uid)) begin
          tag_state_nxt = TS_READY;
          dec_fixed = 1'b1;
          dec_crc = 1'b1;
          dec_bytes = {32'h0, SAK_CL1};
        end else if (rx_buf_r[0] == SEL_CL2 && uid_match(uid_cl2, sel_uid)) begin
          tag_state_nxt = TS_ACTIVE;
          dec_fixed = 1'b1;
          dec_crc = 1'b1;
          dec_bytes = {32'h0, SAK_CL2};
        end
      end
    end else begin
      tag_state_nxt = TS_ACTIVE;
      if (!crc_ok || rx_nbytes_r < LEN_HALT) begin
        dec_fixed = 1'b1;
        dec_bytes = {32'h0, NAK_CRC_PARITY};
        dec_bits = BITS_NIBBLE;
      end else if (rx_buf_r[0] == CMD_HALT && rx_buf_r[1] == HALT_ARG && rx_nbytes_r == LEN_HALT) begin
        tag_state_nxt = TS_HALT;
        dec_halt = 1'b1;
      end else if (rx_buf_r[0] == CMD_READ && rx_nbytes_r == LEN_READ) begin
        if (s > cfg.last_block || (protection_level_bit_on && s >= cfg.first_protected_block)) begin
          dec_fixed = 1'b1;
          dec_bytes = {32'h0, NAK_INVALID_ARG};
          dec_bits = BITS_NIBBLE;
        end else begin
          dec_read = 1'b1;
        end
      end else if (rx_buf_r[0] == CMD_FAST_READ && rx_nbytes_r == LEN_FAST_READ) begin
        if (e < s || e > cfg.last_block || (protection_level_bit_on && e >= cfg.first_protected_block)) begin
          dec_fixed = 1'b1;
          dec_bytes = {32'h0, NAK_INVALID_ARG};
          dec_bits = BITS_NIBBLE;
        end else begin
          dec_read = 1'b1;
          dec_wrap = e;
          dec_count = {1'b0, e} - {1'b0, s} + 9'h001;
        end
      // handed to the write, password, signature, page-read and lock logic
      end else if (rx_buf_r[0] == CMD_WRITE || rx_buf_r[0] == CMD_COMP_WRITE ||
                   rx_buf_r[0] == CMD_PASSWORD_CHECK || rx_buf_r[0] == CMD_SIGNATURE_READ ||
                   rx_buf_r[0] == CMD_PAGE_READ_64 || rx_buf_r[0] == CMD_PAGE_WRITE_64 ||
                   rx_buf_r[0] == CMD_DATA_MEMORY_PASSWORD_CHECK ||
                   rx_buf_r[0] == CMD_GET_READ_LOCK_BITS || rx_buf_r[0] == CMD_GET_WRITE_LOCK_BITS ||
                   rx_buf_r[0] == CMD_SET_READ_LOCK_BITS || rx_buf_r[0] == CMD_SET_WRITE_LOCK_BITS) begin
        dec_ext = 1'b1;
      end else begin
        tag_state_nxt = TS_IDLE;
      end
    end
  end

  // Frames arriving while a reply is pending are dropped; the reader must not talk over us.
  assign dec_go = rx_eof && rs_r == RS_IDLE;

  // Tag state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_state_r <= TS_IDLE;
    end else if (dec_go) begin
      tag_state_r <= tag_state_nxt;
    end
  end

  // authentication flag; a successful check wins over a halt in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auth_r <= 1'b0;
    end else if (password_check_ok && tag_state_r == TS_ACTIVE) begin
      auth_r <= 1'b1;
    end else if (dec_go && (dec_halt || tag_state_nxt != TS_ACTIVE)) begin
      auth_r <= 1'b0;
    end
  end

  // Commands served elsewhere leave as a one-cycle strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_cmd <= '0;
    end else begin
      ext_cmd.valid <= dec_go && dec_ext;
      if (dec_go && dec_ext) begin
        ext_cmd.code <= rx_buf_r[0];
        ext_cmd.arg <= rx_buf_r[1];
      end
    end
  end

  // Responder pushes; the buffer's ready stalls every step.
  always_comb begin
    push = 1'b0;
    push_entry = '0;
    if (rs_r == RS_FIXED) begin
      push = buf_in_ready;
      push_entry.data = fixed_r[{idx_r, 3'b000} +: 8];
      push_entry.nbits = fixed_bits_r;
      push_entry.last = idx_r == fixed_len_r - 3'h1 && !add_crc_r;
    end else if (rs_r == RS_WORD) begin
      push = buf_in_ready;
      push_entry.data = word_r[{idx_r[1:0], 3'b000} +: 8];
      push_entry.nbits = BITS_BYTE;
    end else if (rs_r == RS_CRC) begin
      push = buf_in_ready;
      push_entry.data = idx_r[0] ? tx_crc_r[15:8] : tx_crc_r[7:0];
      push_entry.nbits = BITS_BYTE;
      push_entry.last = idx_r[0];
    end
  end

  assign mem_rd_req = rs_r == RS_FETCH;
  assign mem_addr = blk_r;

  // Reply sequencer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_r <= RS_IDLE;
      fixed_r <= 40'h0;
      fixed_len_r <= LEN_ONE;
      fixed_bits_r <= BITS_BYTE;
      add_crc_r <= 1'b0;
      idx_r <= 3'h0;
      blk_r <= 8'h00;
      wrap_r <= 8'h00;
      blocks_left_r <= 9'h000;
      word_r <= 32'h0;
      timer_r <= '0;
      started_r <= 1'b0;
    end else begin
      if (rs_r != RS_IDLE) begin
        timer_r <= timer_r + 1'b1;
      end
      case (rs_r)
        RS_IDLE: begin
          if (dec_go && (dec_fixed || dec_read)) begin
            rs_r <= RS_WAIT;
            fixed_r <= dec_bytes;
            fixed_len_r <= dec_len;
            fixed_bits_r <= dec_bits;
            add_crc_r <= dec_crc || dec_read;
            blk_r <= dec_blk;
            wrap_r <= dec_wrap;
            blocks_left_r <= dec_count;
            idx_r <= 3'h0;
            timer_r <= '0;
            started_r <= dec_fixed;
          end
        end
        RS_WAIT: begin
          // hold the reply until the frame delay
          if (timer_r >= TIMER_W'(FDT_CYCLES - 1)) begin
            rs_r <= started_r ? RS_FIXED : RS_FETCH;
          end
        end
        RS_FIXED: begin
          if (push) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == fixed_len_r - 3'h1) begin
              idx_r <= 3'h0;
              rs_r <= add_crc_r ? RS_CRC : RS_IDLE;
            end
          end
        end
        RS_FETCH: begin
          // a first fetch of a reply that never answers is abandoned at the time-out
          if (!started_r && timer_r >= TIMER_W'(TIMEOUT_CYCLES - 1)) begin
            rs_r <= RS_IDLE;
          end else if (mem_rd_valid) begin
            started_r <= 1'b1;
            word_r <= mem_rdata;
            if (blk_r == cfg.password_block) begin
              word_r <= 32'h0;
            end else if (blk_r == cfg.password_acknowledge_block) begin
              word_r <= {mem_rdata[31:16], 16'h0000};
            end
            idx_r <= 3'h0;
            rs_r <= RS_WORD;
          end
        end
        RS_WORD: begin
          if (push) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r[1:0] == LAST_BYTE_OF_BLOCK) begin
              idx_r <= 3'h0;
              blocks_left_r <= blocks_left_r - 9'h001;
              blk_r <= (blk_r == wrap_r) ? 8'h00 : blk_r + 8'h01;
              rs_r <= (blocks_left_r == 9'h001) ? RS_CRC : RS_FETCH;
            end
          end
        end
        RS_CRC: begin
          if (push) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r[0]) begin
              idx_r <= 3'h0;
              rs_r <= RS_IDLE;
            end
          end
        end
        default: begin
          rs_r <= RS_IDLE;
        end
      endcase
    end
  end

  // check sequence over the reply bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_crc_r <= CRC_PRESET;
    end else if (rs_r == RS_WAIT) begin
      tx_crc_r <= CRC_PRESET;
    end else if (push && rs_r != RS_CRC) begin
      tx_crc_r <= crc_a_byte(tx_crc_r, push_entry.data);
    end
  end

  // Two-entry buffer so a stall at the modulator loses nothing.
  assign buf_in_ready = buf_cnt_r != 2'(BUF_DEPTH);
  assign buf_out_valid = buf_cnt_r != 2'h0;
  assign buf_pop = buf_out_valid && !ser_busy_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      buf_cnt_r <= 2'h0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else begin
      if (push) begin
        buf_r[wr_ptr_r] <= push_entry;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (buf_pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      buf_cnt_r <= buf_cnt_r + 2'(push) - 2'(buf_pop);
    end
  end

  // serializer, low bit first; the end marker follows the last bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_shift_r <= 8'h00;
      ser_left_r <= 4'h0;
      ser_last_r <= 1'b0;
      ser_busy_r <= 1'b0;
      tx_eof <= 1'b0;
    end else begin
      tx_eof <= 1'b0;
      if (buf_pop) begin
        ser_shift_r <= buf_r[rd_ptr_r].data;
        ser_left_r <= buf_r[rd_ptr_r].nbits;
        ser_last_r <= buf_r[rd_ptr_r].last;
        ser_busy_r <= 1'b1;
      end else if (ser_busy_r && tx_bit_ready) begin
        ser_shift_r <= {1'b0, ser_shift_r[7:1]};
        ser_left_r <= ser_left_r - 4'h1;
        if (ser_left_r == 4'h1) begin
          ser_busy_r <= 1'b0;
          tx_eof <= ser_last_r;
        end
      end
    end
  end

  assign tx_bit_valid = ser_busy_r;
  assign tx_bit = ser_shift_r[0];
  assign selected = tag_state_r == TS_ACTIVE;
  assign authenticated = auth_r;

endmodule : rf_tag_command_decoder

// ---- hdl/rf_tag_pkg.sv ----
// Constants, types and helpers shared by the contactless tag command decoder.
package rf_tag_pkg;

  // Short frame codes, seven bits wide.
  localparam logic [6:0] CMD_REQUEST = 7'h26;
  localparam logic [6:0] CMD_WAKEUP = 7'h52;
  localparam int SHORT_FRAME_BITS = 7;

  // Anticollision and halt prefixes.
  localparam logic [7:0] SEL_CL1 = 8'h93;
  localparam logic [7:0] SEL_CL2 = 8'h95;
  localparam logic [7:0] NVB_ANTICOLL = 8'h20;
  localparam logic [7:0] NVB_SELECT = 8'h70;
  localparam logic [7:0] CMD_HALT = 8'h50;
  localparam logic [7:0] HALT_ARG = 8'h00;

  // Tag memory, data memory and lock commands.
  localparam logic [7:0] CMD_READ = 8'h30;
  localparam logic [7:0] CMD_FAST_READ = 8'h3A;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] CMD_COMP_WRITE = 8'hA0;
  localparam logic [7:0] CMD_PASSWORD_CHECK = 8'h1B;
  localparam logic [7:0] CMD_SIGNATURE_READ = 8'h3C;
  localparam logic [7:0] CMD_PAGE_READ_64 = 8'h51;
  localparam logic [7:0] CMD_PAGE_WRITE_64 = 8'h54;
  localparam logic [7:0] CMD_DATA_MEMORY_PASSWORD_CHECK = 8'h40;
  localparam logic [7:0] CMD_GET_READ_LOCK_BITS = 8'h6A;
  localparam logic [7:0] CMD_GET_WRITE_LOCK_BITS = 8'h6C;
  localparam logic [7:0] CMD_SET_READ_LOCK_BITS = 8'h7F;
  localparam logic [7:0] CMD_SET_WRITE_LOCK_BITS = 8'h7E;

  // Four-bit answers.
  localparam logic [7:0] ACK_CODE = 8'h0A;
  localparam logic [7:0] NAK_INVALID_ARG = 8'h00;
  localparam logic [7:0] NAK_CRC_PARITY = 8'h01;
  localparam logic [7:0] NAK_WRITE_FAIL = 8'h05;

  // Fixed replies.
  localparam logic [15:0] ATQA_VALUE = 16'h0044;
  localparam logic [7:0] SAK_CL1 = 8'h04;
  localparam logic [7:0] SAK_CL2 = 8'h00;
  localparam logic [7:0] FIRST_PROTECTED_BLOCK_DISABLED = 8'hFF;

  // Frame lengths in bytes, the trailing two-byte check included except for anticollision, which has none.
  localparam logic [3:0] LEN_ANTICOLL = 4'h2;
  localparam logic [3:0] LEN_HALT = 4'h4;
  localparam logic [3:0] LEN_READ = 4'h4;
  localparam logic [3:0] LEN_FAST_READ = 4'h5;
  localparam logic [3:0] LEN_SELECT = 4'h9;
  localparam int RX_MAX_BYTES = 9;
  localparam logic [3:0] RX_COUNT_MAX = 4'hF;

  // Reply lengths and widths.
  localparam logic [2:0] LEN_ATQA = 3'h2;
  localparam logic [2:0] LEN_UID = 3'h5;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_NIBBLE = 4'h4;
  localparam logic [8:0] BLOCKS_PER_READ = 9'h004;
  localparam logic [1:0] LAST_BYTE_OF_BLOCK = 2'h3;
  localparam int BUF_DEPTH = 2;

  // Check sequence preset and reflected polynomial.
  localparam logic [15:0] CRC_PRESET = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  // Frame delay time n=9 in carrier periods, carrier 13.56 MHz, clock 200 MHz.
  localparam int FDT_N = 9;
  localparam int FDT_PER_N = 128;
  localparam int FDT_OFFSET = 84;
  localparam int CARRIER_KHZ = 13560;
  localparam int CLK_MHZ = 200;
  localparam int FDT_MIN_CYC = ((FDT_N * FDT_PER_N + FDT_OFFSET) * CLK_MHZ * 1000 + CARRIER_KHZ - 1) / CARRIER_KHZ;
  localparam int TIMEOUT_US = 5000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TIMER_W = 21;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] nbits;
    logic last;
  } tx_entry_t;

  typedef struct packed {
    logic [7:0] last_block;
    logic [7:0] first_protected_block;
    logic protection_level_bit;
    logic [7:0] password_block;
    logic [7:0] password_acknowledge_block;
  } tag_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] arg;
  } ext_cmd_t;

  // One byte of the Type A check sequence, low bit first.
  function automatic logic [15:0] crc_a_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_a_byte

endpackage : rf_tag_pkg

// ---- test/rf_tag_asserts.sv ----
// Port assertions for the contactless tag command decoder.
`timescale 1ns/1ps
module rf_tag_asserts
  import rf_tag_pkg::*;
#(parameter int unsigned FDT_CYCLES = 20) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_eof,
  input wire logic password_check_ok,
  input wire logic mem_rd_req,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_addr,
  input wire ext_cmd_t ext_cmd,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic tx_eof,
  input wire logic tx_bit_ready,
  input wire logic selected,
  input wire logic authenticated
);
  logic [15:0] since_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_stall; tx_bit_valid && !tx_bit_ready; endsequence
  sequence s_quiet; !tx_bit_valid [*8]; endsequence
  // Cycles since the last reader frame ended; it saturates so a long idle never wraps.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_r <= 16'h0000;
    end else begin
      since_r <= rx_eof ? 16'h0000 : since_r + {15'h0000, since_r != 16'hFFFF};
    end
  end
  tx_hold_a: assert property (s_stall |=> tx_bit_valid && $stable(tx_bit)) else $error("bit moved");
  fdt_min_a: assert property ($rose(tx_bit_valid) |-> 32'(since_r) >= FDT_CYCLES) else $error("early");
  eof_after_a: assert property (tx_eof |-> $past(tx_bit_valid) && $past(tx_bit_ready) ##1 !tx_eof)
    else $error("eof");
  mem_drop_a: assert property (mem_rd_req && mem_rd_valid |=> !mem_rd_req) else $error("req held");
  addr_hold_a: assert property (mem_rd_req && !mem_rd_valid |=> $stable(mem_addr)) else $error("addr");
  auth_set_a: assert property ($rose(authenticated) |-> $past(password_check_ok)) else $error("auth");
  auth_clear_a: assert property ((!selected && !password_check_ok) [*2] |-> !authenticated)
    else $error("auth kept");
  ext_quiet_a: assert property (ext_cmd.valid |=> !ext_cmd.valid ##0 s_quiet) else $error("ext");
endmodule : rf_tag_asserts
bind rf_tag_command_decoder rf_tag_asserts #(.FDT_CYCLES(FDT_CYCLES)) i_chk (.*);

// ---- test/reader_model.sv ----
// Reader model: takes reply bits with random stalls and packs them into units.
`timescale 1ns/1ps
module reader_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic tx_eof,
  output logic tx_bit_ready,
  output logic got_stb,
  output logic [7:0] got,
  output logic [3:0] got_bits
);
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {tx_bit_ready, got_stb, got, got_bits, sh_r, cnt_r} <= 26'h0000000;
    end else begin
      got_stb <= 1'b0;
      // Stalls are random so that held bits get tested, not only prompt ones.
      tx_bit_ready <= ($urandom % 3) != 0;
      if (tx_bit_valid && tx_bit_ready) begin
        sh_r <= {tx_bit, sh_r[7:1]};
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'h7) begin
          {got_stb, got, got_bits, cnt_r} <= {1'b1, tx_bit, sh_r[7:1], 4'h8, 4'h0};
        end
      end else if (tx_eof && cnt_r != 4'h0) begin
        {got_stb, got, got_bits, cnt_r} <= {1'b1, sh_r >> (4'h8 - cnt_r), cnt_r, 4'h0};
      end
    end
  end
endmodule : reader_model

// ---- test/testbench.sv ----
// Self-checking bench for the tag command decoder with a reader model.
`timescale 1ns/1ps
module testbench
  import rf_tag_pkg::*;
;
  localparam logic [7:0] PW = 8'h2B, PK = 8'h2C;
  logic clk, rst_n, rx_bit_valid, rx_bit, rx_eof, rx_parity_err, password_check_ok, mem_rd_req, mem_rd_valid;
  logic tx_bit_valid, tx_bit, tx_eof, tx_bit_ready, selected, authenticated, got_stb;
  logic [7:0] mem_addr, got, fq[$], dq[$];
  logic [3:0] got_bits;
  logic [31:0] mem_rdata;
  logic [39:0] uid_cl1, uid_cl2;
  tag_cfg_t cfg;
  ext_cmd_t ext_cmd;
  logic [11:0] exq[$];
  logic [7:0] codes[11] = '{8'h1B, 8'h3C, 8'hA2, 8'hA0, 8'h51, 8'h54, 8'h40, 8'h6A, 8'h6C, 8'h7F, 8'h7E};
  int miscompares, n_tests, mem_wait;
  rf_tag_command_decoder #(.FDT_CYCLES(20), .TIMEOUT_CYCLES(200)) i_dut (.*);
  reader_model i_rdr (.*);
  // Clock of 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_PRESET;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc
  // Expected byte; also kept for the check sequence that closes the reply.
  task automatic ex(input logic [7:0] b);
    exq.push_back({4'h8, b});
    dq.push_back(b);
  endtask : ex
  task automatic exc();
    logic [15:0] c;
    c = crc(dq);
    ex(c[7:0]);
    ex(c[15:8]);
  endtask : exc
  // Sends fq low bit first, waits for the reply, then keeps the reader quiet.
  task automatic go(input int n, input bit add);
    logic [15:0] c;
    c = crc(fq);
    if (add) fq = {fq, c[7:0], c[15:8]};
    if (n == 0) n = 8 * fq.size();
    for (int i = 0; i < n; i++) begin
      rx_bit_valid <= 1'b1;
      rx_bit <= fq[i / 8][i % 8];
      @(posedge clk);
    end
    {rx_bit_valid, rx_eof, rx_bit} <= {1'b0, 1'b1, ~rx_bit};
    @(posedge clk);
    rx_eof <= 1'b0;
    while (exq.size() != 0) @(posedge clk);
    repeat (40) @(posedge clk);
    dq.delete();
  endtask : go
  // Block b reads as b ^ 11h*k; password bytes are expected as zero.
  task automatic rd(input logic [7:0] c, s, e, w, input bit nak);
    logic [7:0] b;
    b = s;
    fq = '{c, s};
    if (c == 8'h3A) fq.push_back(e);
    if (nak) exq.push_back({4'h4, 8'h00});
    else begin
      for (int i = 0; i < (c == 8'h30 ? 4 : int'(e - s) + 1); i++) begin
        for (int k = 0; k < 4; k++) ex((b == PW || (b == PK && k < 2)) ? 8'h00 : b ^ (8'h11 * 8'(k)));
        b = (b == w) ? 8'h00 : b + 8'h01;
      end
      exc();
    end
    go(0, 1);
  endtask : rd
  task automatic activate(input logic [7:0] req);
    logic [39:0] u;
    fq = '{req};
    ex(8'h44);
    ex(8'h00);
    go(7, 0);
    for (int l = 0; l < 2; l++) begin
      u = l ? uid_cl2 : uid_cl1;
      fq = '{l ? 8'h95 : 8'h93, 8'h20};
      for (int k = 0; k < 5; k++) ex(u[8 * k +: 8]);
      go(0, 0);
      fq = '{l ? 8'h95 : 8'h93, 8'h70};
      for (int k = 0; k < 5; k++) fq.push_back(u[8 * k +: 8]);
      ex(l ? 8'h00 : 8'h04);
      exc();
      go(0, 1);
    end
    check({11'h0, selected}, 12'h001);
  endtask : activate
  // Memory answers after a random wait and scrambles its data bus when idle.
  always @(posedge clk) begin
    if (mem_rd_req && !mem_rd_valid && mem_wait == 0) begin
      mem_rd_valid <= 1'b1;
      mem_rdata <= {mem_addr ^ 8'h33, mem_addr ^ 8'h22, mem_addr ^ 8'h11, mem_addr};
      mem_wait <= $urandom % 4;
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_wait > 0) mem_wait <= mem_wait - 1;
    end
  end
  // Each unit the reader assembles is matched against the oldest expectation.
  always @(posedge clk) begin
    if (got_stb) check({got_bits, got}, exq.size() ? exq.pop_front() : 12'hFFF);
  end
  // A hang ends the run as a mismatch.
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(539));
    {rst_n, rx_bit_valid, rx_bit, rx_eof, rx_parity_err, password_check_ok, mem_rd_valid, mem_wait} = '0;
    {mem_rdata, cfg} = {32'h0000_0000, 8'h2C, 8'h10, 1'b1, PW, PK};
    uid_cl1 = {8'($urandom), $urandom};
    uid_cl2 = {8'($urandom), $urandom};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    activate(8'h26);
    rd(8'h30, 8'h0E, 0, 8'h0F, 0);
    rd(8'h30, 8'h10, 0, 0, 1);
    rd(8'h3A, 8'h03, 8'h05, 0, 0);
    rd(8'h3A, 8'h0E, 8'h10, 0, 1);
    for (int i = 0; i < 2; i++) begin
      rx_parity_err <= i[0];
      fq = '{8'h30, 8'h00, 8'h00, 8'h00};
      exq.push_back({4'h4, 8'h01});
      go(0, 0);
    end
    rx_parity_err <= 1'b0;
    password_check_ok <= 1'b1;
    @(posedge clk);
    password_check_ok <= 1'b0;
    @(posedge clk);
    check({11'h0, authenticated}, 12'h001);
    rd(8'h30, 8'h2A, 0, 8'h2C, 0);
    rd(8'h30, 8'h2D, 0, 0, 1);
    rd(8'h3A, 8'h2B, 8'h2D, 0, 1);
    foreach (codes[i]) begin
      fq = '{codes[i], 8'(i)};
      go(0, 1);
      check({ext_cmd.arg[3:0], ext_cmd.code}, {4'(i), codes[i]});
    end
    fq = '{8'h50, 8'h00};
    go(0, 1);
    check({10'h0, selected, authenticated}, 12'h000);
    fq = '{8'h30, 8'h10};
    go(0, 1);
    fq = '{8'h26};
    go(7, 0);
    check({11'h0, selected}, 12'h000);
    cfg.first_protected_block <= 8'hFF;
    activate(8'h52);
    rd(8'h30, 8'h10, 0, 8'h2C, 0);
    finish_test();
  end
endmodule : testbench
